//--- design/spi_chain_port.sv
/*
 * Daisy-chain serial register port: 16-bit pass-through shifter with
 * frame decode at select rise and a 128 x 8 register array.
 * Assumes sclk, cs_n and sdi are asynchronous pins, slow enough (>= 4 mclk
 * per half period) for the 25 MHz sampling clock to see every edge.
 */
`timescale 1ns/1ps
module spi_chain_port
    import spi_chain_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    output logic wr_stb,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [DATA_W-1:0] wr_data
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_edge_if sclk_e ();
    pin_edge_if cs_e ();
    pin_edge_if sdi_e ();

    pin_sync #(.RST_VAL(1'b0)) u_sclk (.mclk(mclk), .rst_n(rst_n), .pin(sclk), .out(sclk_e));
    pin_sync #(.RST_VAL(1'b1)) u_cs (.mclk(mclk), .rst_n(rst_n), .pin(cs_n), .out(cs_e));
    pin_sync #(.RST_VAL(1'b0)) u_sdi (.mclk(mclk), .rst_n(rst_n), .pin(sdi), .out(sdi_e));

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        link_state_t state;
        logic [FRAME_BITS-1:0] shreg;
        logic [CNT_W-1:0] cnt;
        logic rd_pend;
        logic [ADDR_W-1:0] rd_addr;
        logic sdo;
        logic oe;
        logic wstb;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
    } port_t;

    port_t st_r;
    port_t st_nxt;
    logic [DATA_W-1:0] regs_r [NUM_REGS];
    logic [FRAME_BITS-1:0] shifted;

    // Sampling the data pin alongside the clock keeps their relative timing.
    assign shifted = {st_r.shreg[FRAME_BITS-2:0], sdi_e.level};

    always_comb begin
        st_nxt = st_r;
        st_nxt.wstb = 1'b0;
        unique case (st_r.state)
            ST_IDLE: begin
                st_nxt.oe = 1'b0;
                if (cs_e.fall) begin
                    st_nxt.state = ST_ACTIVE;
                    st_nxt.cnt = '0;
                    st_nxt.oe = 1'b1;
                    if (st_r.rd_pend) begin
                        // Dummy byte leads, then the register content.
                        st_nxt.shreg = {READ_DUMMY, regs_r[st_r.rd_addr]};
                        st_nxt.rd_pend = 1'b0;
                    end
                    st_nxt.sdo = st_nxt.shreg[FRAME_BITS-1];
                end
            end
            ST_ACTIVE: begin
                if (cs_e.rise) begin
                    st_nxt.state = ST_IDLE;
                    st_nxt.oe = 1'b0;
                    if (st_r.cnt >= CNT_FULL && st_r.shreg != FRAME_NOP) begin
                        if (st_r.shreg[DIR_BIT]) begin
                            st_nxt.rd_pend = 1'b1;
                            st_nxt.rd_addr = st_r.shreg[ADDR_MSB:ADDR_LSB];
                        end else begin
                            st_nxt.wstb = 1'b1;
                            st_nxt.waddr = st_r.shreg[ADDR_MSB:ADDR_LSB];
                            st_nxt.wdata = st_r.shreg[DATA_MSB:0];
                        end
                    end
                end else if (sclk_e.rise) begin
                    st_nxt.shreg = shifted;
                    if (st_r.cnt < CNT_FULL) begin
                        st_nxt.cnt = st_r.cnt + 5'h01;
                    end
                end else if (sclk_e.fall) begin
                    st_nxt.sdo = st_r.shreg[FRAME_BITS-1];
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{state: ST_IDLE, shreg: SHIFT_RST, cnt: '0, rd_pend: 1'b0, rd_addr: '0,
                      sdo: 1'b0, oe: 1'b0, wstb: 1'b0, waddr: '0, wdata: REG_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Register array
    // ------------------------------------------------------------
    // No reset on the array keeps it a plain memory; contents are undefined until
    // software writes them.
    always_ff @(posedge mclk) begin
        if (st_r.wstb) begin
            regs_r[st_r.waddr] <= st_r.wdata;
        end
    end

    assign sdo_o = st_r.sdo;
    assign sdo_oe = st_r.oe;
    assign wr_stb = st_r.wstb;
    assign wr_addr = st_r.waddr;
    assign wr_data = st_r.wdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_OE_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_IDLE && !cs_e.fall |=> !sdo_oe)
        else $error("output enabled while deselected");
    AST_OE_ACTIVE: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_IDLE && cs_e.fall |=> sdo_oe)
        else $error("output not enabled after select fall");
    AST_SHIFT: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_ACTIVE && !cs_e.rise && sclk_e.rise
        |=> st_r.shreg == {$past(st_r.shreg[FRAME_BITS-2:0]), $past(sdi_e.level)})
        else $error("shift register did not take input bit");
    AST_IGNORE: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_IDLE && !cs_e.fall |=> $stable(st_r.shreg))
        else $error("shift register moved while deselected");
    AST_SDO_FALL: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_ACTIVE && !cs_e.rise && !sclk_e.rise && sclk_e.fall
        |=> sdo_o == $past(st_r.shreg[FRAME_BITS-1]))
        else $error("output did not advance after falling edge");
    AST_SHORT: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_ACTIVE && cs_e.rise && st_r.cnt < CNT_FULL
        |=> !wr_stb && $stable(st_r.rd_pend))
        else $error("partial frame acted upon");
    AST_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_ACTIVE && cs_e.rise && st_r.cnt == CNT_FULL && !st_r.shreg[DIR_BIT]
        && st_r.shreg != FRAME_NOP |=> wr_stb && wr_data == $past(st_r.shreg[DATA_MSB:0]))
        else $error("full write frame not applied");
    AST_NOP: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_ACTIVE && cs_e.rise && st_r.shreg == FRAME_NOP
        |=> !wr_stb && $stable(st_r.rd_pend))
        else $error("no-operation frame changed state");
    AST_READ: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_IDLE && cs_e.fall && st_r.rd_pend
        |=> st_r.shreg[FRAME_BITS-1:DATA_W] == READ_DUMMY && !st_r.rd_pend)
        else $error("read reply not loaded at select fall");
    AST_READ_DATA: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_IDLE && cs_e.fall && st_r.rd_pend
        |=> st_r.shreg[DATA_MSB:0] == $past(regs_r[st_r.rd_addr]))
        else $error("read reply does not carry register content");
    AST_OE_DROP: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.state == ST_ACTIVE && cs_e.rise |=> !sdo_oe)
        else $error("output still enabled after select rise");
    AST_CNT_SAT: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r.cnt <= CNT_FULL)
        else $error("bit counter ran past a full frame");
endmodule // spi_chain_port

//--- design/spi_chain_pkg.sv
/*
 * Shared constants and types for the daisy-chain serial register port.
 * Assumes one system clock (mclk, 25 MHz); link pins are asynchronous to it.
 */
// Operation
// - Sample input on rising edge, MSB first.
// - Ignore clock and data while select high.
// - Output released while select high.
// - Output advances after each falling edge.
// - Select low: plain 16-bit pass-through shifter.
// - Select rise: decode frame, apply write.
// - Frame: address[15:9], read bit 8, data[7:0].
// - Fewer than sixteen bits: frame discarded.
// - Read decoded; reply loaded at next select fall.
// - Second phase may carry a new instruction.
package spi_chain_pkg;

    localparam int FRAME_BITS = 16;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 9;
    localparam int DIR_BIT = 8;
    localparam int DATA_MSB = 7;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    localparam logic [15:0] FRAME_NOP = 16'hFFFF;
    localparam logic [7:0] READ_DUMMY = 8'hFF;
    localparam logic [15:0] SHIFT_RST = 16'h0000;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int NUM_REGS = 128;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE
    } link_state_t;

endpackage

//--- design/pin_edge_if.sv
/*
 * Carries a synchronised pin level and its edge pulses between modules.
 * Assumes the producer and consumer share mclk.
 */
`timescale 1ns/1ps
interface pin_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

//--- design/pin_sync.sv
/*
 * Two-flop synchroniser with edge detection on the synchronised level.
 * Assumes the input pin is asynchronous to mclk.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pin,
    pin_edge_if.src out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_t;

    sync_t st_r;
    sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= {RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    // The first flop feeds only the second; edges come from later stages.
    assign out.level = st_r.s2;
    assign out.rise = st_r.s2 & ~st_r.s3;
    assign out.fall = ~st_r.s2 & st_r.s3;
endmodule // pin_sync

//--- dv/spi_master_model.sv
/* Serial master model for the register port: frames, select and clock.
   Assumes mclk at 25 MHz; one link clock period is 8 mclk (320 ns). */
`timescale 1ns/1ps
module spi_master_model (
    input wire logic mclk,
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // Sampling late in the high phase keeps clear of the port's three-cycle output lag.
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        @(posedge mclk) cs_n <= 1'b0;
        repeat (6) @(posedge mclk);
        for (int i = n - 1; i >= 0; i--) begin
            sdi <= tx[i];
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
            rx = {rx[30:0], sdo};
            sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (10) @(posedge mclk);
    endtask
    // Clock and data move with select high; an even count leaves the clock low.
    task automatic noise();
        repeat (6) begin
            @(posedge mclk) sclk <= ~sclk;
            sdi <= ~sdi;
            repeat (3) @(posedge mclk);
        end
    endtask
endmodule // spi_master_model

//--- dv/test_daisy_chain_spi_register_port.sv
/* Self-checking bench for the serial register port with a reference model.
   Assumes the package, the design files and the master model come first. */
`timescale 1ns/1ps
module test_daisy_chain_spi_register_port;
    import spi_chain_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sdo_park = 1'b0;
    wire logic sclk, cs_n, sdi;
    logic sdo_o, sdo_oe, wr_stb;
    logic [ADDR_W-1:0] wr_addr, la = '0;
    logic [DATA_W-1:0] wr_data, ld = '0;
    logic [DATA_W-1:0] mem [int];
    logic [31:0] seed = 32'h90D3;
    int mismatches = 0;
    int compares = 0;
    int nstb = 0;
    int nexp = 0;
    // A released output shows the inverse of its last value, never a kind constant.
    wire logic sdo = sdo_oe ? sdo_o : sdo_park;
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        if (sdo_oe === 1'b1) sdo_park <= ~sdo_o;
        if (wr_stb === 1'b1) nstb++;
    end
    spi_chain_port spi_chain_port_i (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data));
    spi_master_model spi_master_model_i (.mclk(mclk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
    function automatic logic [31:0] rnd_next();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wexp(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        nexp++;
        la = a;
        ld = d;
        mem[a] = d;
    endtask
    task automatic run(input logic [31:0] tx, input int n, output logic [31:0] rx);
        spi_master_model_i.xfer(tx, n, rx);
        check("oe_idle", 32'(sdo_oe), 32'h0);
        check("stb_count", nstb, nexp);
        check("wr_addr", 32'(wr_addr), 32'(la));
        check("wr_data", 32'(wr_data), 32'(ld));
    endtask
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        logic [31:0] rx, tx;
        logic [DATA_W-1:0] d;
        logic [ADDR_W-1:0] q [$];
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            tx = rnd_next();
            tx[8] = 1'b0;
            wexp(tx[15:9], tx[7:0]);
            q.push_back(tx[15:9]);
            run(tx, 16, rx);
        end
        foreach (q[i]) begin
            run({16'h0, q[i], 1'b1, 8'hFF}, 16, rx);
            d = mem[q[i]];
            tx = rnd_next();
            tx[8] = 1'b0;
            if (i % 2 == 1) begin
                wexp(tx[15:9], tx[7:0]);
            end else begin
                tx = 32'hFFFF;
            end
            run(tx, 16, rx);
            check("read_data", 32'(rx[7:0]), 32'(d));
        end
        // Three ignored rising edges would complete a thirteen-bit frame if counted.
        spi_master_model_i.noise();
        run({16'h0, 7'h55, 1'b0, 8'hA5}, 13, rx);
        tx = rnd_next();
        tx[8] = 1'b0;
        wexp(tx[15:9], tx[7:0]);
        run(tx, 32, rx);
        check("pass_through", 32'(rx[15:0]), 32'(tx[31:16]));
        final_report();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        final_report();
    end
endmodule // test_daisy_chain_spi_register_port
